/* File: esd_pkg.sv */
// ---------------------------------------------------------------
// Encoder and motor geometry
// ---------------------------------------------------------------
package esd_pkg;

    // Counted increments per shaft revolution
    localparam int ENC_CPR = 4000;
    // Step angle in tenths of a degree, and a turn in the same unit
    localparam int STEP_ANGLE_DECI = 18;
    localparam int DEG_DECI_REV = 3600;
    // Increments per full step
    localparam int EXP_FULL = ENC_CPR * STEP_ANGLE_DECI / DEG_DECI_REV;
    // Finest microstep setting served, as a power of two
    localparam int USTEP_LOG2_MAX = 4;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIR_SETUP_NS = 1000;
    localparam int STEP_HIGH_NS = 1000;
    localparam int STEP_LOW_NS = 1000;
    // Least times round up to whole cycles
    localparam int DIR_SETUP_CYC =
        (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_HIGH_CYC =
        (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_LOW_CYC =
        (STEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Slowest step rate; a longer gap closes the interval
    localparam int STEP_MIN_RATE_HZ = 50;
    localparam int NS_PER_S = 1_000_000_000;
    localparam int INTERVAL_MAX_NS = NS_PER_S / STEP_MIN_RATE_HZ;
    // Longest time rounds down
    localparam int INTERVAL_CYC = INTERVAL_MAX_NS / CLK_PERIOD_NS;
    // Width of the step phase timer
    localparam int TIM_W = 8;

    // ---------------------------------------------------------------
    // Step output sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_HIGH = 4'h4,
        ST_LOW = 4'h8
    } esd_step_st_t;

    // Expected increments per commanded step for a microstep setting
    function automatic int esd_expected(input logic [2:0] ulog);
        int sh;
        sh = (int'(ulog) > USTEP_LOG2_MAX) ? USTEP_LOG2_MAX : int'(ulog);
        return EXP_FULL >> sh;
    endfunction

endpackage

/* File: esd_quad_decoder.sv */
`timescale 1ns/100ps

module esd_quad_decoder (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Encoder pins, asynchronous
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_idx,
    // Decoded one-cycle events
    output logic q_fwd,
    output logic q_rev,
    output logic q_idx,
    output logic q_err
);

    // ---------------------------------------------------------------
    // Synchronisers and edge history
    // ---------------------------------------------------------------
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s3_reg;
    logic [1:0] arm_reg;

    // Two stages, then one stage of history for change detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            s3_reg <= 3'h0;
        end else if (ce) begin
            s1_reg <= {enc_idx, enc_b, enc_a};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Hold off until the history holds real pin levels, else a pin
    // that is high at reset looks like a spurious edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arm_reg <= 2'h0;
        end else if (ce && arm_reg != 2'h3) begin
            arm_reg <= arm_reg + 2'h1;
        end
    end

    // ---------------------------------------------------------------
    // Quadrature decode, four counts per cycle
    // ---------------------------------------------------------------
    wire armed = (arm_reg == 2'h3);
    wire a_chg = s2_reg[0] ^ s3_reg[0];
    wire b_chg = s2_reg[1] ^ s3_reg[1];
    wire moved = a_chg ^ b_chg;
    // Channel A leading B counts forward
    wire fwd_dir = (s3_reg[0] == s2_reg[1]);
    wire idx_rise = s2_reg[2] & ~s3_reg[2];

    // Registered event pulses
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q_fwd <= 1'b0;
            q_rev <= 1'b0;
            q_idx <= 1'b0;
            q_err <= 1'b0;
        end else if (ce) begin
            q_fwd <= armed & moved & fwd_dir;
            q_rev <= armed & moved & ~fwd_dir;
            q_idx <= armed & idx_rise;
            q_err <= armed & a_chg & b_chg; // Both moved: lost edge
        end
    end

endmodule

/* File: esd_stall_detector.sv */
`timescale 1ns/100ps

module esd_stall_detector
    import esd_pkg::*;
#(
    parameter int POS_W = 16,
    parameter int CNT_W = 8,
    parameter int TOL_CNT = 0,
    parameter int INTERVAL_MAX_CYC = INTERVAL_CYC
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Step commands from controller logic
    input wire logic step_req,
    input wire logic step_dir,
    input wire logic [2:0] ustep_log2,
    input wire logic stall_clear,
    output logic step_ready,
    // Stepper driver
    output logic step_out,
    output logic dir_out,
    // Encoder pins
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_idx,
    // Status
    output logic stall_led,
    output logic abnormal,
    output logic index_ref,
    output logic rot_fwd,
    output logic [POS_W-1:0] position,
    output logic [CNT_W-1:0] last_count,
    output logic eval_pulse
);

    localparam int CW1 = CNT_W + 1;
    localparam int IW = $clog2(INTERVAL_MAX_CYC + 1);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (EXP_FULL + TOL_CNT >= (1 << CNT_W) || TOL_CNT < 0) begin : g_bad_cnt
        $error("CNT_W too small for expected count and tolerance");
    end
    if (INTERVAL_MAX_CYC < 2 || POS_W < 2) begin : g_bad_int
        $error("INTERVAL_MAX_CYC and POS_W must be at least 2");
    end
    if (STEP_HIGH_CYC >= (1 << TIM_W) || STEP_LOW_CYC >= (1 << TIM_W) ||
        DIR_SETUP_CYC >= (1 << TIM_W)) begin : g_bad_tim
        $error("Step phase times exceed the phase timer");
    end

    // ---------------------------------------------------------------
    // Encoder decode
    // ---------------------------------------------------------------
    logic q_fwd;
    logic q_rev;
    logic q_idx;
    logic q_err;

    esd_quad_decoder u_dec (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .enc_a(enc_a),
        .enc_b(enc_b),
        .enc_idx(enc_idx),
        .q_fwd(q_fwd),
        .q_rev(q_rev),
        .q_idx(q_idx),
        .q_err(q_err)
    );

    // ---------------------------------------------------------------
    // Step and direction sequencer
    // ---------------------------------------------------------------
    esd_step_st_t st_reg, st_next;
    logic [TIM_W-1:0] tim_reg, tim_next;
    logic dir_reg, dir_next;

    // Direction settles before the edge, so the driver never sees both
    // change together; the cost is a setup delay per step
    assign step_ready = (st_reg == ST_IDLE);
    wire step_go = ce & step_req & step_ready;
    wire [TIM_W-1:0] tim_lim = (st_reg == ST_SETUP) ? TIM_W'(DIR_SETUP_CYC) :
        (st_reg == ST_HIGH) ? TIM_W'(STEP_HIGH_CYC) : TIM_W'(STEP_LOW_CYC);
    wire tim_done = (tim_reg == tim_lim - 1'b1);

    // Next state of the sequencer; each phase ends on its own limit
    always_comb begin
        st_next = st_reg;
        dir_next = dir_reg;
        case (st_reg)
            ST_IDLE: begin
                if (step_req) begin
                    st_next = ST_SETUP;
                    dir_next = step_dir;
                end
            end
            ST_SETUP: st_next = tim_done ? ST_HIGH : ST_SETUP;
            ST_HIGH: st_next = tim_done ? ST_LOW : ST_HIGH;
            ST_LOW: st_next = tim_done ? ST_IDLE : ST_LOW;
            default: st_next = ST_IDLE;
        endcase
    end
    // Phase timer restarts at every change of state and while idle
    assign tim_next = (st_next != st_reg || st_reg == ST_IDLE) ? '0 :
        tim_reg + 1'b1;

    // Sequencer registers and driver pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= ST_IDLE;
            tim_reg <= '0;
            dir_reg <= 1'b0;
            step_out <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
            tim_reg <= tim_next;
            dir_reg <= dir_next;
            step_out <= (st_next == ST_HIGH);
        end
    end
    assign dir_out = dir_reg;

    // ---------------------------------------------------------------
    // Position tracking
    // ---------------------------------------------------------------
    logic [POS_W-1:0] pos_reg, pos_next;

    // Index wins over a count in the same cycle
    assign pos_next = q_idx ? '0 : q_fwd ? pos_reg + 1'b1 :
        q_rev ? pos_reg - 1'b1 : pos_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pos_reg <= '0;
            index_ref <= 1'b0;
            rot_fwd <= 1'b0;
        end else if (ce) begin
            pos_reg <= pos_next;
            index_ref <= index_ref | q_idx;
            if (q_fwd || q_rev) begin
                rot_fwd <= q_fwd;
            end
        end
    end
    assign position = pos_reg;

    // ---------------------------------------------------------------
    // Step interval monitor
    // ---------------------------------------------------------------
    logic mon_reg;
    logic wrong_reg;
    logic [IW-1:0] ivl_reg;
    logic [CNT_W-1:0] cnt_reg, cnt_next;

    // Expected increments for the current microstep setting
    wire [CNT_W-1:0] exp_cnt = CNT_W'(esd_expected(ustep_log2));
    wire timeout = (ivl_reg == IW'(INTERVAL_MAX_CYC - 1));
    // An interval closes at the next command or after the slowest rate
    wire eval = ce & mon_reg & (step_go | timeout);
    wire match = (q_fwd & dir_reg) | (q_rev & ~dir_reg);
    wire counter_dir = (q_fwd & ~dir_reg) | (q_rev & dir_reg) | q_err;
    wire cnt_full = (cnt_reg == {CNT_W{1'b1}});
    wire [CW1-1:0] tol_ext = CW1'(TOL_CNT);
    wire [CW1-1:0] got_ext = {1'b0, cnt_reg};
    wire [CW1-1:0] exp_ext = {1'b0, exp_cnt};
    wire short_cnt = (got_ext + tol_ext) < exp_ext;
    wire over_cnt = got_ext > (exp_ext + tol_ext);
    wire stall_ev = eval & short_cnt;
    wire abn_ev = eval & (short_cnt | over_cnt | wrong_reg);

    // Movement in the eval cycle belongs to the new interval
    assign cnt_next = eval ? {{(CNT_W-1){1'b0}}, match} :
        (match & ~cnt_full) ? cnt_reg + 1'b1 : cnt_reg;

    // Interval timer and counters
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mon_reg <= 1'b0;
            ivl_reg <= '0;
            cnt_reg <= '0;
            wrong_reg <= 1'b0;
        end else if (ce) begin
            mon_reg <= step_go | (mon_reg & ~timeout);
            ivl_reg <= (step_go | ~mon_reg) ? '0 : ivl_reg + 1'b1;
            cnt_reg <= cnt_next;
            wrong_reg <= counter_dir | (wrong_reg & ~eval);
        end
    end

    // Sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stall_led <= 1'b0;
            abnormal <= 1'b0;
            last_count <= '0;
            eval_pulse <= 1'b0;
        end else if (ce) begin
            stall_led <= stall_ev | (stall_led & ~stall_clear);
            abnormal <= abn_ev | (abnormal & ~stall_clear);
            eval_pulse <= eval;
            if (eval) begin
                last_count <= cnt_reg;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [TIM_W-1:0] hi_len_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_len_reg <= '0;
        end else if (ce) begin
            hi_len_reg <= step_out ? hi_len_reg + 1'b1 : '0;
        end
    end

    property p_dir_stable;
        step_out |-> $stable(dir_out);
    endproperty
    a_dir_stable: assert property (p_dir_stable)
        else $error("Direction changed during step pulse");
    property p_high_len;
        $fell(step_out) |-> hi_len_reg == TIM_W'(STEP_HIGH_CYC);
    endproperty
    a_high_len: assert property (p_high_len)
        else $error("Step pulse width wrong");
    property p_stall_set;
        ce && eval && short_cnt |=> stall_led && abnormal && eval_pulse;
    endproperty
    a_stall_set: assert property (p_stall_set)
        else $error("Short interval did not light stall LED");
    property p_stall_cause;
        $rose(stall_led) |-> $past(mon_reg) && $past(cnt_reg) < $past(exp_cnt);
    endproperty
    a_stall_cause: assert property (p_stall_cause)
        else $error("Stall LED lit without a short interval");
    property p_abn_over;
        ce && eval && over_cnt |=> abnormal;
    endproperty
    a_abn_over: assert property (p_abn_over)
        else $error("Excess increments not flagged");
    property p_index;
        ce && q_idx |=> position == '0 && index_ref;
    endproperty
    a_index: assert property (p_index)
        else $error("Index did not zero position");
    property p_pos_fwd;
        ce && q_fwd && !q_idx |=>
            position == $past(position) + 1'b1 && rot_fwd;
    endproperty
    a_pos_fwd: assert property (p_pos_fwd)
        else $error("Forward count not applied");
    property p_pos_rev;
        ce && q_rev && !q_idx |=>
            position == $past(position) - 1'b1 && !rot_fwd;
    endproperty
    a_pos_rev: assert property (p_pos_rev)
        else $error("Reverse count not applied");
    property p_exp_full;
        ustep_log2 == 3'h0 |-> exp_cnt == CNT_W'(ENC_CPR * 18 / 3600);
    endproperty
    a_exp_full: assert property (p_exp_full)
        else $error("Full step expectation wrong");
    property p_exp_half;
        ustep_log2 == 3'h1 |-> exp_cnt == CNT_W'(EXP_FULL / 2);
    endproperty
    a_exp_half: assert property (p_exp_half)
        else $error("Microstep expectation wrong");

    c_stall: cover property (ce && stall_ev);
    c_good: cover property (ce && eval && !abn_ev);
    c_index: cover property (ce && q_idx);
    c_timeout: cover property (ce && mon_reg && timeout);

endmodule

/* File: esd_motor_model.sv */
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Stepper driver and quadrature encoder stand-in
// ---------------------------------------------------------------
module esd_motor_model
    import esd_pkg::*;
#(
    parameter int CPR = ENC_CPR
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Driver pins
    input wire logic step_out,
    input wire logic dir_out,
    // Scenario controls
    input wire logic [7:0] n_edges,
    input wire logic [7:0] gap,
    input wire logic reverse,
    input wire logic glitch,
    // Encoder pins
    output logic enc_a,
    output logic enc_b,
    output logic enc_idx
);
    logic [1:0] ph;
    int ang;

    // Phase order 00-10-11-01 turns forward, A leading B
    task automatic move(input int d);
        ph = ph + 2'(d);
        enc_a = ph[0] ^ ph[1];
        enc_b = ph[1];
        ang = (ang + d + CPR) % CPR;
    endtask

    // Shaft angle restarts so the index lands at a known count
    always @(posedge rst) begin
        ang = 0;
    end

    // Each step pulse turns the shaft by n_edges increments
    initial begin
        ph = 2'b00;
        ang = 0;
        enc_a = 1'b0;
        enc_b = 1'b0;
        enc_idx = 1'b0;
        forever begin
            @(posedge step_out);
            for (int i = 0; i < int'(n_edges); i++) begin
                repeat (gap) @(posedge ref_clk);
                #1;
                // Glitch flips both channels at once, first edge only
                if (glitch && i == 0) begin
                    move(2);
                end else begin
                    move((dir_out ^ reverse) ? 1 : -1);
                end
                // One index pulse per turn, wide enough to be seen
                if (ang == 0) begin
                    @(posedge ref_clk);
                    #1 enc_idx = 1'b1;
                    repeat (3) @(posedge ref_clk);
                    #1 enc_idx = 1'b0;
                end
            end
        end
    end
endmodule

/* File: test_esd_stall_detector.sv */
`timescale 1ns/100ps

module test_esd_stall_detector;
    import esd_pkg::*;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic ref_clk, rst, ce, step_req, step_dir, stall_clear;
    logic [2:0] ustep_log2;
    logic step_ready, step_out, dir_out, enc_a, enc_b, enc_idx;
    logic stall_led, abnormal, index_ref, rot_fwd, eval_pulse;
    logic [15:0] position;
    logic [7:0] last_count, n_edges, gap;
    logic reverse, glitch;
    int num_errors, n_checks;
    // Expected phase lengths and the shortened interval limit
    localparam int STEP_CYC = DIR_SETUP_CYC + STEP_HIGH_CYC + STEP_LOW_CYC;
    localparam int FALL_CYC = DIR_SETUP_CYC + STEP_HIGH_CYC + 1;
    localparam int IVL_CYC = 500;

    // Short timeout; steps come sooner except in the refused-request and timeout scenarios
    esd_stall_detector #(.INTERVAL_MAX_CYC(IVL_CYC)) uut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .step_req(step_req),
        .step_dir(step_dir), .ustep_log2(ustep_log2),
        .stall_clear(stall_clear), .step_ready(step_ready),
        .step_out(step_out), .dir_out(dir_out), .enc_a(enc_a),
        .enc_b(enc_b), .enc_idx(enc_idx), .stall_led(stall_led),
        .abnormal(abnormal), .index_ref(index_ref), .rot_fwd(rot_fwd),
        .position(position), .last_count(last_count),
        .eval_pulse(eval_pulse)
    );

    // Small turn so the index comes within three steps
    esd_motor_model #(.CPR(60)) motor (
        .ref_clk(ref_clk), .rst(rst), .step_out(step_out),
        .dir_out(dir_out), .n_edges(n_edges), .gap(gap),
        .reverse(reverse), .glitch(glitch), .enc_a(enc_a),
        .enc_b(enc_b), .enc_idx(enc_idx)
    );

    // 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
    endtask

    // One step, timed from the taking edge
    task automatic do_step(input logic d, output logic ev,
        output logic [7:0] lc);
        int rise, fall, rdy;
        rise = 0;
        fall = 0;
        rdy = 0;
        step_req = 1'b1;
        step_dir = d;
        @(negedge ref_clk);
        step_req = 1'b0;
        ev = eval_pulse;
        lc = last_count;
        check("step_ready", step_ready, 0);
        check("dir_out", dir_out, d);
        for (int k = 2; k <= 400 && rdy == 0; k++) begin
            @(negedge ref_clk);
            if (step_out === 1'b1 && rise == 0) rise = k;
            if (step_out === 1'b0 && rise != 0 && fall == 0) fall = k;
            if (step_ready === 1'b1) rdy = k;
        end
        check("step rise", rise, DIR_SETUP_CYC + 1);
        check("step fall", fall, FALL_CYC);
        check("ready", rdy, STEP_CYC + 1);
    endtask

    // Opening step with n edges, then a closing step that judges it
    task automatic run_pair(input logic [2:0] u, input logic d,
        input logic [7:0] n, input logic [7:0] ec, input logic es,
        input logic ea);
        logic ev;
        logic [7:0] lc;
        do_reset();
        ustep_log2 = u;
        n_edges = n;
        do_step(d, ev, lc);
        check("first eval", ev, 0);
        n_edges = 8'h00;
        do_step(d, ev, lc);
        check("eval_pulse", ev, 1);
        check("last_count", lc, ec);
        check("stall_led", stall_led, es);
        check("abnormal", abnormal, ea);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Every microstep code, exact count and one short
    task automatic t_ustep();
        int e;
        logic [7:0] n;
        logic s;
        for (int u = 0; u < 8; u++) begin
            e = ENC_CPR * STEP_ANGLE_DECI / DEG_DECI_REV;
            e = e >> (u > USTEP_LOG2_MAX ? USTEP_LOG2_MAX : u);
            for (int k = 0; k < 2; k++) begin
                n = 8'(e - k);
                s = (k == 1);
                run_pair(3'(u), 1'b1, n, n, s, s);
                check("position", position, 32'(16'(e - k)));
            end
        end
    endtask

    // Too many increments is abnormal but no stall
    task automatic t_excess();
        run_pair(3'h0, 1'b1, 8'h15, 8'h15, 1'b0, 1'b1);
    endtask

    // Backward run with a slow encoder
    task automatic t_backward();
        gap = 8'h08;
        run_pair(3'h0, 1'b0, 8'h14, 8'h14, 1'b0, 1'b0);
        check("position", position, 16'hffec);
        check("rot_fwd", rot_fwd, 0);
        gap = 8'h04;
    endtask

    // Shaft turns against the command, then the flags are cleared
    task automatic t_wrong_dir();
        reverse = 1'b1;
        run_pair(3'h0, 1'b1, 8'h14, 8'h00, 1'b1, 1'b1);
        reverse = 1'b0;
        check("rot_fwd", rot_fwd, 0);
        stall_clear = 1'b1;
        @(negedge ref_clk);
        stall_clear = 1'b0;
        check("cleared", {stall_led, abnormal}, 0);
    endtask

    // Both channels flip together on the first edge
    task automatic t_glitch();
        glitch = 1'b1;
        run_pair(3'h0, 1'b1, 8'h15, 8'h14, 1'b0, 1'b1);
        glitch = 1'b0;
    endtask

    // Index after one turn zeroes the position
    task automatic t_index();
        logic ev;
        logic [7:0] lc;
        do_reset();
        ustep_log2 = 3'h0;
        n_edges = 8'h14;
        do_step(1'b1, ev, lc);
        do_step(1'b1, ev, lc);
        check("position", position, 16'h0028);
        check("index_ref", index_ref, 0);
        do_step(1'b1, ev, lc);
        check("position", position, 16'h0000);
        check("index_ref", index_ref, 1);
        check("stall_led", stall_led, 0);
    endtask

    // Requests held while busy are not queued
    task automatic t_refused();
        int rises;
        logic prev;
        rises = 0;
        prev = 1'b0;
        do_reset();
        n_edges = 8'h00;
        step_req = 1'b1;
        for (int k = 0; k < 700; k++) begin
            if (k == 100) step_req = 1'b0;
            @(negedge ref_clk);
            if (step_out === 1'b1 && prev === 1'b0) rises++;
            prev = step_out;
        end
        check("step count", rises, 1);
        check("step_ready", step_ready, 1);
    endtask

    // Slow interval closes by timeout; its stall beats a clear
    task automatic t_timeout();
        logic ev;
        logic [7:0] lc;
        do_reset();
        n_edges = 8'h13;
        do_step(1'b1, ev, lc);
        repeat (IVL_CYC - STEP_CYC - 1) @(negedge ref_clk);
        check("no early eval", eval_pulse, 0);
        stall_clear = 1'b1;
        @(negedge ref_clk);
        stall_clear = 1'b0;
        check("timeout eval", eval_pulse, 1);
        check("timeout count", last_count, 8'h13);
        check("stall beats clear", stall_led, 1);
        n_edges = 8'h00;
        do_step(1'b1, ev, lc);
        check("idle opens only", ev, 0);
        check("stall held", {stall_led, abnormal}, 2'h3);
    endtask

    // Clock enable low freezes the sequencer in the middle of a step
    task automatic t_freeze();
        int rise;
        rise = 0;
        do_reset();
        n_edges = 8'h00;
        step_dir = 1'b1;
        step_req = 1'b1;
        @(negedge ref_clk);
        step_req = 1'b0;
        ce = 1'b0;
        repeat (2 * DIR_SETUP_CYC) @(negedge ref_clk);
        check("frozen", {step_ready, step_out, dir_out}, 3'h1);
        ce = 1'b1;
        for (int k = 2; k <= STEP_CYC && rise == 0; k++) begin
            @(negedge ref_clk);
            if (step_out === 1'b1) rise = k;
        end
        check("thawed rise", rise, DIR_SETUP_CYC + 1);
    endtask

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        num_errors = 0;
        n_checks = 0;
        rst = 1'b1;
        ce = 1'b1;
        step_req = 1'b0;
        step_dir = 1'b0;
        stall_clear = 1'b0;
        ustep_log2 = 3'h0;
        n_edges = 8'h00;
        gap = 8'h04;
        reverse = 1'b0;
        glitch = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("reset step", {step_out, dir_out, step_ready}, 3'h1);
        check("reset flags", {stall_led, abnormal, eval_pulse}, 0);
        check("reset pos", {index_ref, rot_fwd, position}, 0);
        rst = 1'b0;
        @(negedge ref_clk);
        t_ustep();
        t_excess();
        t_backward();
        t_wrong_dir();
        t_glitch();
        t_index();
        t_refused();
        t_timeout();
        t_freeze();
        conclude();
    end

    // Whole run needs about 15k cycles; the limit allows 30k
    initial begin
        #300_000;
        num_errors++;
        conclude();
    end
endmodule
